// >>> hdl/buck_fault_map.vh
`ifndef BUCK_FAULT_MAP_VH
`define BUCK_FAULT_MAP_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CTRL_OFFSET     12'h000
`define STATUS_OFFSET   12'h004
`define TIMER_OFFSET    12'h008

// ----------------------------------------------------------------------
// Control fields: detector enables
// ----------------------------------------------------------------------
`define CTRL_OC_EN_BIT  0
`define CTRL_SC_EN_BIT  1
`define CTRL_OV_EN_BIT  2
`define CTRL_UV_EN_BIT  3
`define CTRL_OT_EN_BIT  4
`define CTRL_WIDTH      5
`define CTRL_RESET      5'h1f

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define ST_OC_BIT       0
`define ST_SC_BIT       1
`define ST_OV_BIT       2
`define ST_UV_BIT       3
`define ST_OT_BIT       4
`define ST_CROWBAR_BIT  5
`define ST_SWITCH_BIT   6
`define ST_CODE_LSB     8

// ----------------------------------------------------------------------
// First-fault codes
// ----------------------------------------------------------------------
`define CODE_NONE       2'h0
`define CODE_CURRENT    2'h1
`define CODE_OVER_V     2'h2
`define CODE_UNDER_V    2'h3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_FREQ_MHZ    200
`define OC_TIME_US      20
`define SC_TIME_US      10

`endif

// >>> hdl/buck_fault_protection_ctrl.v
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "buck_fault_map.vh"

module buck_fault_protection_ctrl #(
  parameter CNT_W = 13
) (
  // Clock and reset
  input  wire        clk_in,
  input  wire        reset_in,
  // APB slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  // Comparator and pin inputs, asynchronous
  input  wire        enable_in,
  input  wire        supply_por_low_in,
  input  wire        low_side_window_in,
  input  wire        above_oc_in,
  input  wire        above_sc_in,
  input  wire        fb_above_ov_rise_in,
  input  wire        fb_below_ov_fall_in,
  input  wire        fb_below_uv_in,
  input  wire        overtemp_rise_in,
  input  wire        overtemp_below_hys_in,
  input  wire        soft_start_in,
  // Power stage controls
  output reg         switching_enable_out,
  output reg         low_side_force_out,
  // Power-ok open-drain pull-down enables
  output reg         power_ok_strong_oe_out,
  output reg         power_ok_medium_oe_out,
  output reg         power_ok_weak_oe_out
);

  // ----------------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------------
  localparam integer     OC_CYC_I = `OC_TIME_US * `CLK_FREQ_MHZ;
  localparam integer     SC_CYC_I = `SC_TIME_US * `CLK_FREQ_MHZ;
  localparam [CNT_W-1:0] OC_CYC   = OC_CYC_I[CNT_W-1:0];
  localparam [CNT_W-1:0] SC_CYC   = SC_CYC_I[CNT_W-1:0];
  localparam             NSYNC  = 11;

  function [CNT_W-1:0] inc_sat;
    input [CNT_W-1:0] v;
    begin
      inc_sat = (&v) ? v : v + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  reg [NSYNC-1:0] meta_r;
  reg [NSYNC-1:0] sync_r;
  reg             window_d_r;

  wire [NSYNC-1:0] async_pins = {soft_start_in, overtemp_below_hys_in, overtemp_rise_in,
                                 fb_below_uv_in, fb_below_ov_fall_in, fb_above_ov_rise_in,
                                 above_sc_in, above_oc_in, low_side_window_in,
                                 supply_por_low_in, enable_in};

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      meta_r     <= {NSYNC{1'b0}};
      sync_r     <= {NSYNC{1'b0}};
      window_d_r <= 1'b0;
    end else begin
      meta_r     <= async_pins;
      sync_r     <= meta_r;
      window_d_r <= sync_r[2];
    end
  end

  wire en_s      = sync_r[0];
  wire por_s     = sync_r[1];
  wire window_s  = sync_r[2];
  wire oc_s      = sync_r[3];
  wire sc_s      = sync_r[4];
  wire ov_rise_s = sync_r[5];
  wire ov_fall_s = sync_r[6];
  wire uv_s      = sync_r[7];
  wire ot_rise_s = sync_r[8];
  wire ot_hys_s  = sync_r[9];
  wire ss_s      = sync_r[10];

  // Either event wipes every latch and the temperature state.
  wire clear_evt = ~en_s | por_s;

  // One sample per switching cycle, at the start of the low-side window.
  wire sample = window_s & ~window_d_r;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  reg [`CTRL_WIDTH-1:0] ctrl_r;
  reg                   oc_lat_r;
  reg                   sc_lat_r;
  reg                   ov_lat_r;
  reg                   uv_lat_r;
  reg                   ot_susp_r;
  reg                   crowbar_r;
  reg [1:0]             code_r;
  reg                   oc_run_r;
  reg [CNT_W-1:0]       oc_cnt_r;
  reg                   sc_prev_r;
  reg [CNT_W-1:0]       sc_cnt_r;

  wire latched = oc_lat_r | sc_lat_r | ov_lat_r | uv_lat_r;

  // ----------------------------------------------------------------------
  // Current fault timers
  // ----------------------------------------------------------------------
  // The timer runs on clock cycles from the first qualifying sample, so
  // any number of pulses may fall inside the window.
  reg              oc_run_nxt;
  reg [CNT_W-1:0]  oc_cnt_nxt;
  reg              sc_prev_nxt;
  reg [CNT_W-1:0]  sc_cnt_nxt;
  reg              oc_hit;
  reg              sc_hit;

  always @* begin
    oc_run_nxt  = oc_run_r;
    oc_cnt_nxt  = oc_run_r ? inc_sat(oc_cnt_r) : {CNT_W{1'b0}};
    sc_prev_nxt = sc_prev_r;
    sc_cnt_nxt  = inc_sat(sc_cnt_r);
    sc_hit      = 1'b0;
    if (sample) begin
      if (oc_s) begin
        oc_run_nxt = 1'b1;
      end else begin
        oc_run_nxt = 1'b0;
        oc_cnt_nxt = {CNT_W{1'b0}};
      end
      sc_hit      = sc_s & sc_prev_r & (sc_cnt_r < SC_CYC);
      sc_prev_nxt = sc_s;
      sc_cnt_nxt  = {CNT_W{1'b0}};
    end
    oc_hit = oc_run_r & (oc_cnt_r >= OC_CYC) & ~(sample & ~oc_s);
    if (clear_evt | latched) begin
      oc_run_nxt  = 1'b0;
      oc_cnt_nxt  = {CNT_W{1'b0}};
      sc_prev_nxt = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Fault set conditions
  // ----------------------------------------------------------------------
  wire set_oc = oc_hit & ctrl_r[`CTRL_OC_EN_BIT];
  wire set_sc = sc_hit & ctrl_r[`CTRL_SC_EN_BIT];
  wire set_ov = ov_rise_s & en_s & ctrl_r[`CTRL_OV_EN_BIT];
  // Undervoltage is watched even while over-temperature holds switching.
  wire set_uv = uv_s & en_s & ~ss_s & ctrl_r[`CTRL_UV_EN_BIT];
  wire set_ot = ot_rise_s & ctrl_r[`CTRL_OT_EN_BIT];

  reg [1:0] code_nxt;

  always @* begin
    code_nxt = clear_evt ? `CODE_NONE : code_r;
    if (code_r == `CODE_NONE) begin
      if (set_oc | set_sc) begin
        code_nxt = `CODE_CURRENT;
      end else if (set_ov) begin
        code_nxt = `CODE_OVER_V;
      end else if (set_uv) begin
        code_nxt = `CODE_UNDER_V;
      end
    end
  end

  // A fault arriving in the clearing cycle keeps its latch: set wins, but clear wins for crowbar_r.
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      oc_lat_r  <= 1'b0;
      sc_lat_r  <= 1'b0;
      ov_lat_r  <= 1'b0;
      uv_lat_r  <= 1'b0;
      ot_susp_r <= 1'b0;
      crowbar_r <= 1'b0;
      code_r    <= `CODE_NONE;
      oc_run_r  <= 1'b0;
      oc_cnt_r  <= {CNT_W{1'b0}};
      sc_prev_r <= 1'b0;
      sc_cnt_r  <= {CNT_W{1'b0}};
    end else begin
      oc_lat_r  <= set_oc | (oc_lat_r & ~clear_evt);
      sc_lat_r  <= set_sc | (sc_lat_r & ~clear_evt);
      ov_lat_r  <= set_ov | (ov_lat_r & ~clear_evt);
      uv_lat_r  <= set_uv | (uv_lat_r & ~clear_evt);
      if (set_ot) begin
        ot_susp_r <= 1'b1;
      end else if (ot_hys_s | clear_evt) begin
        ot_susp_r <= 1'b0;
      end
      if (clear_evt) begin
        crowbar_r <= 1'b0;
      end else if ((ov_lat_r | set_ov) & ov_rise_s) begin
        crowbar_r <= 1'b1;
      end else if (ov_lat_r & ov_fall_s) begin
        crowbar_r <= 1'b0;
      end
      code_r    <= code_nxt;
      oc_run_r  <= oc_run_nxt;
      oc_cnt_r  <= oc_cnt_nxt;
      sc_prev_r <= sc_prev_nxt;
      sc_cnt_r  <= sc_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Power stage and power-ok outputs
  // ----------------------------------------------------------------------
  // The flag is one clock behind its set, so the set term also gates the
  // switching_enable_out to cut a cycle of switching after a fault.
  wire any_set   = set_oc | set_sc | set_ov | set_uv;
  wire switch_ok = en_s & ~por_s & ~latched & ~any_set & ~ot_susp_r & ~set_ot;

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      switching_enable_out   <= 1'b0;
      low_side_force_out     <= 1'b0;
      power_ok_strong_oe_out <= 1'b0;
      power_ok_medium_oe_out <= 1'b0;
      power_ok_weak_oe_out   <= 1'b0;
    end else begin
      switching_enable_out   <= switch_ok;
      low_side_force_out     <= crowbar_r;
      power_ok_strong_oe_out <= en_s & (code_r == `CODE_CURRENT);
      power_ok_medium_oe_out <= en_s & (code_r == `CODE_OVER_V);
      power_ok_weak_oe_out   <= en_s & ((code_r == `CODE_UNDER_V) |
                                        ((code_r == `CODE_NONE) & ss_s));
    end
  end

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  // No wait states: pready rises in the first access cycle.
  wire setup    = psel_in & ~penable_in;
  wire hit_ctrl = (paddr_in == `CTRL_OFFSET);
  wire hit_stat = (paddr_in == `STATUS_OFFSET);
  wire hit_tmr  = (paddr_in == `TIMER_OFFSET);
  wire mapped   = hit_ctrl | hit_stat | hit_tmr;
  wire do_write = psel_in & penable_in & pready_out & pwrite_in & hit_ctrl;

  reg [31:0] rdata;

  always @* begin
    rdata = 32'h0000_0000;
    if (hit_ctrl) begin
      rdata[`CTRL_WIDTH-1:0] = ctrl_r;
    end else if (hit_stat) begin
      rdata[`ST_OC_BIT]      = oc_lat_r;
      rdata[`ST_SC_BIT]      = sc_lat_r;
      rdata[`ST_OV_BIT]      = ov_lat_r;
      rdata[`ST_UV_BIT]      = uv_lat_r;
      rdata[`ST_OT_BIT]      = ot_susp_r;
      rdata[`ST_CROWBAR_BIT] = crowbar_r;
      rdata[`ST_SWITCH_BIT]  = switching_enable_out;
      rdata[`ST_CODE_LSB+:2] = code_r;
    end else if (hit_tmr) begin
      rdata[CNT_W-1:0] = oc_cnt_r;
    end
  end

  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl_r      <= `CTRL_RESET;
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= setup;
      if (setup) begin
        prdata_out  <= pwrite_in ? 32'h0000_0000 : rdata;
        pslverr_out <= ~mapped;
      end else if (~psel_in) begin
        pslverr_out <= 1'b0;
      end
      if (do_write) begin
        ctrl_r <= pwdata_in[`CTRL_WIDTH-1:0];
      end
    end
  end

endmodule

// >>> tb/buck_fault_chk.sv
`timescale 1ns/1ps
module buck_fault_chk #(
  parameter CNT_W = 13
) (
  // Clock, reset and register bus
  input logic        clk_in, reset_in, psel_in, penable_in, pwrite_in,
  input logic [11:0] paddr_in,
  input logic [31:0] pwdata_in, prdata_out,
  input logic        pready_out, pslverr_out,
  // Pins and power stage
  input logic        enable_in, supply_por_low_in, low_side_window_in, above_oc_in,
  input logic        above_sc_in, fb_above_ov_rise_in, fb_below_ov_fall_in, fb_below_uv_in,
  input logic        overtemp_rise_in, overtemp_below_hys_in, soft_start_in,
  input logic        switching_enable_out, low_side_force_out,
  input logic        power_ok_strong_oe_out, power_ok_medium_oe_out, power_ok_weak_oe_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // Pins reach the outputs through two sync flops, so runs of four samples are used.
  // An output copying a flag that a pin clears lags one edge more, so it gets five.
  wire ok_w = enable_in && !supply_por_low_in;
  wire [2:0] pg_w = {power_ok_strong_oe_out, power_ok_medium_oe_out, power_ok_weak_oe_out};

  a_apb_ready: assert property (psel_in && !penable_in |=> pready_out ##1 !pready_out)
    else $error("pready is not one cycle after setup");
  a_apb_unmapped: assert property (psel_in && !penable_in && paddr_in != 12'h000 &&
    paddr_in != 12'h004 && paddr_in != 12'h008 |=> pslverr_out)
    else $error("unmapped address gave no slave error");
  a_cur_latch: assert property (power_ok_strong_oe_out |-> !switching_enable_out)
    else $error("switching while current fault shown");
  a_ov_latch: assert property (low_side_force_out || power_ok_medium_oe_out
    |-> !switching_enable_out) else $error("switching while overvoltage latched");
  a_uv_latch: assert property ((!soft_start_in)[*4] ##0 power_ok_weak_oe_out
    |-> !switching_enable_out) else $error("switching while undervoltage latched");
  a_clear_all: assert property ((!ok_w)[*5] |-> !switching_enable_out &&
    !power_ok_strong_oe_out && !power_ok_medium_oe_out && !low_side_force_out)
    else $error("enable low or supply reset did not stop and clear");
  a_crowbar_off: assert property (fb_below_ov_fall_in[*5] |-> !low_side_force_out)
    else $error("low side still forced below falling point");
  a_ot_hold: assert property (overtemp_rise_in[*4] |-> !switching_enable_out)
    else $error("switching while over temperature");
  a_first_hold: assert property (ok_w[*3] ##0 (pg_w[2] || pg_w[1]) |=> $stable(pg_w))
    else $error("power ok code changed while latched");
  a_pg_code: assert property ($onehot0(pg_w))
    else $error("more than one pull-down on");
  c_strong: cover property (power_ok_strong_oe_out);
  c_medium: cover property (power_ok_medium_oe_out);
  c_weak: cover property (power_ok_weak_oe_out && !soft_start_in);
  c_force: cover property ($rose(low_side_force_out));
endmodule

// >>> tb/power_stage_model.sv
`timescale 1ns/1ps
module power_stage_model (
  // Clock and sensed current level: 0 low, 1 overcurrent, 2 short circuit
  input  wire        clk_in,
  input  wire  [1:0] level_in,
  input  wire  [7:0] period_in,
  // Window and comparators
  output logic       window_out = 1'h0,
  output logic       oc_out     = 1'h0,
  output logic       sc_out     = 1'h0
);
  logic [7:0] cnt_r = 8'h0;
  // From count 8'h1c on, after the low-side window, the comparators toggle, so sampling there shows up.
  always @(posedge clk_in) begin
    cnt_r <= (cnt_r >= period_in - 8'h1) ? 8'h0 : cnt_r + 8'h1;
    window_out <= cnt_r >= 8'h4 && cnt_r < 8'h18;
    if (cnt_r < 8'h1c) {oc_out, sc_out} <= {level_in != 2'h0, level_in == 2'h2};
    else {oc_out, sc_out} <= ~{oc_out, sc_out};
  end
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        clk_in = 1'h0, reset_in = 1'h1, psel_in = 1'h0, penable_in = 1'h0;
  logic        pwrite_in = 1'h0, enable_in = 1'h1, supply_por_low_in = 1'h0;
  logic [11:0] paddr_in = 12'h0;
  logic [31:0] pwdata_in = 32'h0;
  logic        fb_above_ov_rise_in = 1'h0, fb_below_ov_fall_in = 1'h1, fb_below_uv_in = 1'h0;
  logic        overtemp_rise_in = 1'h0, overtemp_below_hys_in = 1'h1, soft_start_in = 1'h0;
  logic [1:0]  cur_lvl = 2'h0;
  logic [7:0]  period = 8'h64;
  wire         low_side_window_in, above_oc_in, above_sc_in, pready_out, pslverr_out;
  wire  [31:0] prdata_out;
  wire         switching_enable_out, low_side_force_out;
  wire         power_ok_strong_oe_out, power_ok_medium_oe_out, power_ok_weak_oe_out;
  integer      mismatches = 0, n_compared = 0, cycles = 0, seed = 32'ha420c015;
  logic [36:0] exp_q[$], msk_q[$], e, m;

  buck_fault_protection_ctrl buck_fault_protection_ctrl_inst (.*);
  power_stage_model power_stage_model_inst (.clk_in(clk_in), .level_in(cur_lvl),
    .period_in(period), .window_out(low_side_window_in), .oc_out(above_oc_in),
    .sc_out(above_sc_in));

  always #2.5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches = mismatches + 1;
      finish_test();
    end
  end

  // Each completed transfer is checked against the oldest noted expectation.
  always @(posedge clk_in) begin
    if (psel_in && penable_in && pready_out === 1'h1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      n_compared = n_compared + 1;
      if (({power_ok_strong_oe_out, power_ok_medium_oe_out, power_ok_weak_oe_out,
            low_side_force_out, pslverr_out, prdata_out} & m) !== e) begin
        mismatches = mismatches + 1;
        $display("BAD apb %h exp %h got %h", paddr_in, e, {power_ok_strong_oe_out,
          power_ok_medium_oe_out, power_ok_weak_oe_out, low_side_force_out,
          pslverr_out, prdata_out} & m);
      end
    end
  end

  task w(input integer n);
    repeat (n) @(posedge clk_in);
  endtask

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
           input logic [36:0] mk, input logic [36:0] ex);
    begin
      exp_q.push_back(ex);
      msk_q.push_back(mk);
      @(posedge clk_in);
      {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'h2, wr, a, d};
      @(posedge clk_in);
      penable_in <= 1'h1;
      @(posedge clk_in);
      while (pready_out !== 1'h1) @(posedge clk_in);
      {psel_in, penable_in} <= 2'h0;
    end
  endtask

  task st(input logic [9:0] s, input logic [3:0] p);
    apb(1'h0, 12'h004, 32'h0, {5'h1f, 32'h37f}, {p, 23'h0, s});
  endtask

  task fb(input logic [2:0] v);
    begin
      {fb_above_ov_rise_in, fb_below_ov_fall_in, fb_below_uv_in} <= v;
      w(6);
    end
  endtask

  task clr(input logic por);
    begin
      @(posedge clk_in);
      if (por) supply_por_low_in <= 1'h1;
      else enable_in <= 1'h0;
      w(6);
      {enable_in, supply_por_low_in} <= 2'h2;
      w(6);
    end
  endtask

  task finish_test;
    begin
      if (mismatches == 0 && n_compared > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  initial begin
    period <= 8'h32 + ($random(seed) & 8'h3f);
    w(6);
    reset_in <= 1'h0;
    w(4);
    apb(1'h0, 12'h000, 32'h0, {5'h1f, 32'hffffffff}, {5'h0, 32'h1f});
    st(10'h040, 4'h0);
    apb(1'h0, 12'h00c, 32'h0, {5'h1f, 32'hffffffff}, {5'h1, 32'h0});
    apb(1'h1, 12'h004, 32'h3ff, {5'h1, 32'h0}, 37'h0);
    apb(1'h1, 12'h000, 32'h0, {5'h1, 32'h0}, 37'h0);
    cur_lvl <= 2'h2;
    w(400);
    st(10'h040, 4'h0);
    apb(1'h1, 12'h000, 32'h1f, {5'h1, 32'h0}, 37'h0);
    w(400);
    st(10'h102, 4'h8);
    clr(1'h0);
    cur_lvl <= 2'h1;
    w(2000);
    cur_lvl <= 2'h0;
    w(250);
    apb(1'h0, 12'h008, 32'h0, {5'h0, 32'h1fff}, 37'h0);
    cur_lvl <= 2'h1;
    w(3000);
    st(10'h040, 4'h0);
    period <= 8'h32 + ($random(seed) & 8'h3f);
    w(1500);
    st(10'h101, 4'h8);
    clr(1'h0);
    st(10'h040, 4'h0);
    cur_lvl <= 2'h0;
    fb(3'h4);
    st(10'h224, 4'h5);
    fb(3'h0);
    st(10'h224, 4'h5);
    fb(3'h2);
    st(10'h204, 4'h4);
    fb(3'h4);
    st(10'h224, 4'h5);
    fb(3'h2);
    clr(1'h1);
    st(10'h040, 4'h0);
    soft_start_in <= 1'h1;
    fb(3'h3);
    st(10'h040, 4'h2);
    soft_start_in <= 1'h0;
    w(6);
    st(10'h308, 4'h2);
    fb(3'h4);
    st(10'h32c, 4'h3);
    fb(3'h2);
    clr(1'h0);
    {overtemp_rise_in, overtemp_below_hys_in} <= 2'h2;
    w(6);
    st(10'h010, 4'h0);
    overtemp_rise_in <= 1'h0;
    w(6);
    st(10'h010, 4'h0);
    overtemp_below_hys_in <= 1'h1;
    w(6);
    st(10'h040, 4'h0);
    {overtemp_rise_in, overtemp_below_hys_in} <= 2'h2;
    w(6);
    fb(3'h3);
    st(10'h318, 4'h2);
    fb(3'h2);
    overtemp_rise_in <= 1'h0;
    clr(1'h0);
    st(10'h040, 4'h0);
    finish_test();
  end
endmodule

bind buck_fault_protection_ctrl buck_fault_chk #(.CNT_W(CNT_W)) buck_fault_chk_inst (.*);
